// file: hdl/uart_rx_pkg.sv
// Shared constants and types for the serial receive and transmit-end block
package uart_rx_pkg;
  // Register byte offsets on the APB slave
  localparam logic [11:0] MODE_OFF = 12'h000;    // mode_control_reg
  localparam logic [11:0] TSTAT_OFF = 12'h004;   // transmit_status_reg
  localparam logic [11:0] ERR_OFF = 12'h008;     // rx_error_status
  localparam logic [11:0] TXBUF_OFF = 12'h00C;   // transmit_buffer
  localparam logic [11:0] RXBUF_OFF = 12'h010;   // receive_buffer
  localparam logic [11:0] BAUD_OFF = 12'h014;    // baud divisor
  // mode_control_reg fields
  localparam int UNIT_BIT = 7;
  localparam int TXON_BIT = 6;
  localparam int RXON_BIT = 5;
  localparam int PAR_LSB = 3;
  localparam int LEN8_BIT = 2;
  localparam int STOP2_BIT = 1;
  localparam int MERGE_BIT = 0;
  localparam logic [7:0] MODE_RST = 8'h01;
  // rx_error_status fields
  localparam int PE_BIT = 2;
  localparam int FE_BIT = 1;
  localparam int OVE_BIT = 0;
  // Parity types
  localparam logic [1:0] PAR_NONE = 2'b00;
  localparam logic [1:0] PAR_ZERO = 2'b01;
  localparam logic [1:0] PAR_ODD = 2'b10;
  localparam logic [1:0] PAR_EVEN = 2'b11;
  // Baud divisor: clocks per bit
  localparam logic [15:0] BAUD_RST = 16'h00AE;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_LOAD = 3'b100
  } tx_state_t;
  typedef struct packed {
    logic done;
    logic error;
  } rx_irq_t;
endpackage

// file: hdl/uart_rx_unit.sv
// Serial receiver with error flags and transmitter with continuous-send status
`timescale 1ns/1ps
module uart_rx_unit (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_o,
  output logic tx_done_irq_o,
  output uart_rx_pkg::rx_irq_t rx_irq_o
);
  import uart_rx_pkg::*;

  logic [7:0] mode_reg;
  logic [15:0] baud_reg;
  logic [2:0] err_reg;
  logic [7:0] rx_buf_reg;
  logic rx_buf_unread_reg;
  logic [7:0] tx_buf_reg;
  logic tx_full_reg;
  logic tx_busy_reg;
  logic [1:0] rx_sync_reg;
  logic rx_prev_reg;
  rx_state_t rx_state_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [8:0] rx_shift_reg;
  tx_state_t tx_state_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0] tx_idx_reg;
  logic [11:0] tx_shift_reg;
  logic [3:0] tx_bits_reg;

  logic rx_line;
  logic unit_on, tx_on, rx_on, merge;
  logic [1:0] par_type;
  logic [3:0] data_bits;
  logic [3:0] rx_last;
  logic access, wr, rd;
  logic rx_mid, rx_end, tx_tick;
  logic frame_done, par_err, frm_err, ovr_err, any_err;
  logic [7:0] rx_data;
  logic [15:0] half_baud;
  logic tx_ones;
  logic tx_slot;
  logic [11:0] tx_frame;

  assign rx_line = rx_sync_reg[1];
  assign unit_on = mode_reg[UNIT_BIT];
  assign tx_on = unit_on & mode_reg[TXON_BIT];
  assign rx_on = unit_on & mode_reg[RXON_BIT];
  assign merge = mode_reg[MERGE_BIT];
  assign par_type = mode_reg[PAR_LSB +: 2];
  assign data_bits = mode_reg[LEN8_BIT] ? 4'd8 : 4'd7;
  // Index of the stop bit, which follows the parity bit when present
  assign rx_last = (par_type == PAR_NONE) ? data_bits : data_bits + 4'd1;
  assign access = psel_i & penable_i & pready_o;
  assign wr = access & pwrite_i;
  assign rd = access & ~pwrite_i;
  assign half_baud = {1'b0, baud_reg[15:1]};
  assign rx_mid = (rx_cnt_reg == half_baud);
  assign rx_end = (rx_cnt_reg == baud_reg - 16'd1);
  assign tx_tick = (tx_cnt_reg == baud_reg - 16'd1);

  // Pin synchroniser; only the second stage is looked at
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sync_reg <= 2'b11;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], serial_in_pin_i};
      rx_prev_reg <= rx_line;
    end
  end

  // APB slave: zero wait states, unmapped reads return zero with pslverr
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i & ~penable_i) begin
        unique case (paddr_i)
          MODE_OFF: prdata_o <= {24'h00_0000, mode_reg};
          TSTAT_OFF: prdata_o <= {30'h0000_0000, tx_full_reg, tx_busy_reg};
          ERR_OFF: prdata_o <= {29'h0000_0000, err_reg};
          TXBUF_OFF: prdata_o <= {24'h00_0000, tx_buf_reg};
          RXBUF_OFF: prdata_o <= {24'h00_0000, rx_buf_reg};
          BAUD_OFF: prdata_o <= {16'h0000, baud_reg};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= MODE_RST;
      baud_reg <= BAUD_RST;
    end else if (wr) begin
      if (paddr_i == MODE_OFF) mode_reg <= pwdata_i[7:0];
      if (paddr_i == BAUD_OFF) baud_reg <= (pwdata_i[15:0] < 16'd2) ? 16'd2 : pwdata_i[15:0];
    end
  end

  // Receiver
  assign frame_done = rx_on && rx_state_reg == RX_STOP && rx_mid;
  assign rx_data = mode_reg[LEN8_BIT] ? rx_shift_reg[7:0] : {1'b0, rx_shift_reg[6:0]};
  always_comb begin
    par_err = 1'b0;
    if (par_type == PAR_EVEN) par_err = ^{rx_data, rx_shift_reg[8]};
    if (par_type == PAR_ODD) par_err = ~^{rx_data, rx_shift_reg[8]};
  end
  assign frm_err = ~rx_line;
  assign ovr_err = rx_buf_unread_reg;
  assign any_err = par_err | frm_err | ovr_err;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else if (!rx_on) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_idx_reg <= 4'h0;
    end else begin
      rx_cnt_reg <= rx_end ? 16'h0000 : rx_cnt_reg + 16'd1;
      unique case (rx_state_reg)
        RX_IDLE: begin
          rx_cnt_reg <= 16'h0000;
          if (rx_prev_reg & ~rx_line) begin
            // The detection cycle is already the first clock of the start bit,
            // so counting from one puts every sample at the centre of its bit
            rx_cnt_reg <= 16'h0001;
            rx_state_reg <= RX_START;
          end
        end
        RX_START: if (rx_mid) begin
          rx_idx_reg <= 4'h0;
          rx_state_reg <= rx_line ? RX_IDLE : RX_BITS;
        end
        RX_BITS: if (rx_mid) begin
          // Data bits land LSB first; the parity bit goes to bit 8
          if (rx_idx_reg < data_bits) rx_shift_reg[rx_idx_reg[2:0]] <= rx_line;
          else rx_shift_reg[8] <= rx_line;
          rx_idx_reg <= rx_idx_reg + 4'd1;
          if (rx_idx_reg == rx_last - 4'd1) rx_state_reg <= RX_STOP;
        end
        RX_STOP: if (rx_mid) rx_state_reg <= RX_IDLE;
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Buffer, error flags and receive interrupts; a new error wins over the read clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_buf_reg <= 8'h00;
      rx_buf_unread_reg <= 1'b0;
      err_reg <= 3'b000;
      rx_irq_o <= '0;
    end else begin
      rx_irq_o <= '0;
      // Only what the read returned is cleared: a flag set after the setup cycle
      // was never seen by the host and must survive until the next read
      if (rd && paddr_i == ERR_OFF) err_reg <= err_reg & ~prdata_o[2:0];
      if (rd && paddr_i == RXBUF_OFF) rx_buf_unread_reg <= 1'b0;
      if (frame_done) begin
        if (!ovr_err) begin
          rx_buf_reg <= rx_data;
          rx_buf_unread_reg <= 1'b1;
        end
        if (any_err) begin
          err_reg <= (rd && paddr_i == ERR_OFF ? err_reg & ~prdata_o[2:0] : err_reg)
                     | {par_err, frm_err, ovr_err};
        end
        rx_irq_o.done <= ~any_err | merge;
        rx_irq_o.error <= any_err & ~merge;
      end
    end
  end

  // Frame image, LSB first: start, data, parity slot, then ones for the stop bits.
  // Without parity the slot itself is the first stop bit.
  assign tx_ones = (^tx_buf_reg[6:0]) ^ (mode_reg[LEN8_BIT] & tx_buf_reg[7]);
  always_comb begin
    tx_slot = 1'b1;
    if (par_type == PAR_EVEN) tx_slot = tx_ones;
    if (par_type == PAR_ODD) tx_slot = ~tx_ones;
    if (par_type == PAR_ZERO) tx_slot = 1'b0;
    tx_frame = {2'b11, tx_slot, tx_buf_reg, 1'b0};
    if (!mode_reg[LEN8_BIT]) tx_frame = {3'b111, tx_slot, tx_buf_reg[6:0], 1'b0};
  end

  // Transmitter: buffer-full and shifting status through continuous sending
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_reg <= TX_IDLE;
      tx_buf_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 16'h0000;
      tx_idx_reg <= 4'h0;
      tx_bits_reg <= 4'h0;
      tx_shift_reg <= 12'hFFF;
      serial_out_o <= 1'b1;
      tx_done_irq_o <= 1'b0;
    end else if (!tx_on) begin
      // Disabling flushes the transmitter without a done interrupt
      tx_state_reg <= TX_IDLE;
      tx_full_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 16'h0000;
      serial_out_o <= 1'b1;
      tx_done_irq_o <= 1'b0;
    end else begin
      tx_done_irq_o <= 1'b0;
      if (wr && paddr_i == TXBUF_OFF) begin
        tx_buf_reg <= pwdata_i[7:0];
        tx_full_reg <= 1'b1;
      end
      unique case (tx_state_reg)
        TX_IDLE: if (tx_full_reg) tx_state_reg <= TX_LOAD;
        TX_LOAD: begin
          tx_shift_reg <= tx_frame;
          tx_bits_reg <= 4'd2 + data_bits + (par_type != PAR_NONE ? 4'd1 : 4'd0)
                         + (mode_reg[STOP2_BIT] ? 4'd1 : 4'd0);
          tx_idx_reg <= 4'h0;
          tx_cnt_reg <= 16'h0000;
          tx_full_reg <= (wr && paddr_i == TXBUF_OFF);
          tx_busy_reg <= 1'b1;
          tx_state_reg <= TX_SHIFT;
        end
        TX_SHIFT: begin
          serial_out_o <= tx_shift_reg[tx_idx_reg];
          tx_cnt_reg <= tx_tick ? 16'h0000 : tx_cnt_reg + 16'd1;
          if (tx_tick) begin
            tx_idx_reg <= tx_idx_reg + 4'd1;
            if (tx_idx_reg == tx_bits_reg - 4'd1) begin
              tx_done_irq_o <= 1'b1;
              serial_out_o <= 1'b1;
              if (tx_full_reg) begin
                tx_state_reg <= TX_LOAD;
              end else begin
                tx_busy_reg <= 1'b0;
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end
endmodule

// file: verification/uart_far_end.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module uart_far_end #(
  parameter int DIV = 4
) (
  input wire logic clk_i,
  input wire logic tx_line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // Start, eight data bits LSB first, parity slot, stop; a low stop forces a framing fault
  task automatic send(input logic [7:0] d, input logic par, input logic stop);
    logic [10:0] frame;
    frame = {stop, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= frame[i];
      repeat (DIV) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
  // A low pulse one clock long, far shorter than any start bit
  task automatic glitch();
    line_o <= 1'b0;
    @(posedge clk_i);
    line_o <= 1'b1;
  endtask
  // Collects one eleven-bit frame from the block's transmit line, each bit at its centre
  task automatic recv(output logic [10:0] frame);
    @(negedge tx_line_i);
    repeat (DIV / 2) @(posedge clk_i);
    frame[0] = tx_line_i;
    for (int i = 1; i < 11; i++) begin
      repeat (DIV) @(posedge clk_i);
      frame[i] = tx_line_i;
    end
  endtask
endmodule

// file: verification/uart_receive_and_tx_end_test.sv
// Self-checking bench for the receive path and transmit-end status
`timescale 1ns/1ps
module uart_receive_and_tx_end_test;
  import uart_rx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, serial_in_pin_i, serial_out_o, tx_done_irq_o, err;
  logic [10:0] frame;
  rx_irq_t rx_irq_o;
  int mismatches = 0;
  int total_checks = 0;
  int n_done = 0;
  int n_err = 0;
  int n_tx = 0;
  always #25 clk_i = ~clk_i;
  uart_rx_unit u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .serial_in_pin_i(serial_in_pin_i), .serial_out_o(serial_out_o),
    .tx_done_irq_o(tx_done_irq_o), .rx_irq_o(rx_irq_o));
  uart_far_end #(.DIV(4)) u_far (.clk_i(clk_i), .tx_line_i(serial_out_o),
    .line_o(serial_in_pin_i));
  always @(posedge clk_i) begin
    n_done += (rx_irq_o.done === 1'b1);
    n_err += (rx_irq_o.error === 1'b1);
    n_tx += (tx_done_irq_o === 1'b1);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) mismatches++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  // Waits out the frame plus the input synchroniser delay
  task automatic rx(input logic [7:0] d, input logic par, input logic stop);
    @(posedge clk_i);
    u_far.send(d, par, stop);
    repeat (12) @(posedge clk_i);
  endtask
  task automatic wait_tx(input int k);
    for (int i = 0; i < 400 && n_tx < k; i++) @(posedge clk_i);
    if (n_tx < k) mismatches++;
  endtask
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk("mode reset", MODE_OFF, {24'h00_0000, MODE_RST});
    rchk("unmapped data", 12'h020, 32'h0000_0000);
    check("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, BAUD_OFF, 32'h0000_0004);
    apb(1'b1, MODE_OFF, 32'h0000_0080);
    apb(1'b1, MODE_OFF, 32'h0000_00FC);
    rx(8'h3C, ~^8'h3C, 1'b1);
    check("error irq", n_err, 1);
    check("done irq", n_done, 0);
    rchk("parity flag", ERR_OFF, 32'h0000_0004);
    rchk("flags cleared", ERR_OFF, 32'h0000_0000);
    rchk("parity frame kept", RXBUF_OFF, 32'h0000_003C);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, MODE_OFF, 32'h0000_00E5 | 32'(p << 3));
      rx(8'h0F, 1'b1, 1'b1);
      check("merged irq", n_done, p + 1);
      rchk("buffer", RXBUF_OFF, 32'h0000_000F);
      rchk("parity type", ERR_OFF, (p == 3) ? 32'h0000_0004 : 32'h0000_0000);
    end
    apb(1'b1, MODE_OFF, 32'h0000_00FD);
    rx(8'h81, ^8'h81, 1'b0);
    check("framing irq", n_done, 5);
    rchk("framing flag", ERR_OFF, 32'h0000_0002);
    rchk("framing frame", RXBUF_OFF, 32'h0000_0081);
    apb(1'b1, MODE_OFF, 32'h0000_00FC);
    rx(8'h11, ^8'h11, 1'b1);
    rx(8'h22, ^8'h22, 1'b1);
    check("overrun irq", n_err, 2);
    rchk("overrun flag", ERR_OFF, 32'h0000_0001);
    rchk("overrun discards", RXBUF_OFF, 32'h0000_0011);
    u_far.glitch();
    repeat (12) @(posedge clk_i);
    check("glitch ignored", n_done + n_err, 8);
    fork
      rx(8'h55, ^8'h55, 1'b0);
      begin
        repeat (12) @(posedge clk_i);
        apb(1'b1, MODE_OFF, 32'h0000_00DC);
      end
    join
    check("abort irqs", n_done + n_err, 8);
    rchk("abort buffer", RXBUF_OFF, 32'h0000_0011);
    rchk("abort flags", ERR_OFF, 32'h0000_0000);
    // Even parity, eight bits, one stop: frame is stop, parity, data, start
    fork
      begin
        u_far.recv(frame);
        check("first frame", 32'(frame), 32'({1'b1, ^8'h5A, 8'h5A, 1'b0}));
        u_far.recv(frame);
        check("last frame", 32'(frame), 32'({1'b1, ^8'hC3, 8'hC3, 1'b0}));
      end
      begin
        apb(1'b1, TXBUF_OFF, 32'h0000_005A);
        repeat (4) @(posedge clk_i);
        rchk("loaded", TSTAT_OFF, 32'h0000_0001);
        apb(1'b1, TXBUF_OFF, 32'h0000_00C3);
        rchk("queued", TSTAT_OFF, 32'h0000_0003);
        wait_tx(1);
        rchk("reload", TSTAT_OFF, 32'h0000_0001);
        wait_tx(2);
        rchk("tx end", TSTAT_OFF, 32'h0000_0000);
      end
    join
    apb(1'b1, MODE_OFF, 32'h0000_00BC);
    check("tx irqs", n_tx, 2);
    apb(1'b1, MODE_OFF, 32'h0000_00DC);
    apb(1'b1, TXBUF_OFF, 32'h0000_0077);
    repeat (8) @(posedge clk_i);
    apb(1'b1, MODE_OFF, 32'h0000_00BC);
    rchk("flushed", TSTAT_OFF, 32'h0000_0000);
    repeat (60) @(posedge clk_i);
    check("no flush irq", n_tx, 2);
    check("line idle", {31'h0000_0000, serial_out_o}, 32'h0000_0001);
    conclude();
  end
endmodule

// file: verification/uart_rx_checker.sv
// Port-level assertions for the receive and transmit-end block
`timescale 1ns/1ps
module uart_rx_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic serial_in_pin_i,
  input wire logic serial_out_o,
  input wire logic tx_done_irq_o,
  input wire uart_rx_pkg::rx_irq_t rx_irq_o
);
  import uart_rx_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Set by a status read, dropped by any receive event, so a second read must see zero
  logic err_read_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_read_reg <= 1'b0;
    end else if (rx_irq_o != 2'b00) begin
      err_read_reg <= 1'b0;
    end else if (psel_i && pready_o && !pwrite_i && paddr_i == ERR_OFF) begin
      err_read_reg <= 1'b1;
    end
  end
  ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in access phase");
  ready_single_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  error_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  unmapped_error_a: assert property (psel_i && pready_o && paddr_i > BAUD_OFF |-> pslverr_o)
    else $error("unmapped access not refused");
  irq_exclusive_a: assert property (!(rx_irq_o.done && rx_irq_o.error))
    else $error("both receive interrupts at once");
  rx_irq_pulse_a: assert property (rx_irq_o != 2'b00 |=> rx_irq_o == 2'b00)
    else $error("receive interrupt longer than one cycle");
  tx_done_line_a: assert property (
    tx_done_irq_o |-> $past(serial_out_o) ##1 !tx_done_irq_o)
    else $error("transmit done not after a high stop bit");
  err_clear_a: assert property (
    psel_i && pready_o && !pwrite_i && paddr_i == ERR_OFF && err_read_reg
    |-> prdata_o == 32'h0000_0000)
    else $error("error status not cleared by read");
  cover property (rx_irq_o.done);
  cover property (rx_irq_o.error);
  cover property (tx_done_irq_o);
endmodule
bind uart_rx_unit uart_rx_checker u_checker (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .serial_in_pin_i(serial_in_pin_i), .serial_out_o(serial_out_o),
  .tx_done_irq_o(tx_done_irq_o), .rx_irq_o(rx_irq_o));
